/* File: cmp_pkg.sv */
package cmp_pkg;
	// Register offsets are multiples of four: printed values are word indices
	localparam logic [7:0] IDX_CONV_B = 8'h03;
	localparam logic [7:0] IDX_CMP_CS = 8'h08;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'h11;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'h12;
	localparam logic [7:0] IDX_CTRL_EXT = 8'h13;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_W = 8;
	// Field positions
	localparam int CONV_B_NEGMUX = 6;
	localparam logic [7:0] CONV_B_WMASK = 8'he7;
	localparam logic [7:0] CONV_B_RESET = 8'h00;
	localparam int CS_POWER_OFF = 7;
	localparam int CS_BANDGAP = 6;
	localparam int CS_OUTPUT = 5;
	localparam int CS_FLAG = 4;
	localparam int CS_IRQ_EN = 3;
	localparam int CS_MODE_HI = 1;
	localparam int CS_MODE_LO = 0;
	localparam int EXT_CONV_EN = 0;
	localparam int EXT_GLOBAL_IE = 1;
	localparam int EXT_CHAN_LO = 2;
	localparam int EXT_CHAN_HI = 3;
	localparam int EXT_BITS = 4;
	localparam int IRQ_EVENT = 0;
	localparam int IRQ_BITS = 1;
	localparam int SYNC_STAGES = 2;
	// Event modes
	localparam logic [1:0] MODE_TOGGLE = 2'h0;
	localparam logic [1:0] MODE_RESVD = 2'h1;
	localparam logic [1:0] MODE_FALL = 2'h2;
	localparam logic [1:0] MODE_RISE = 2'h3;
	localparam logic [31:0] RDATA_UNMAPPED = 32'h00000000;
endpackage

/* File: cmp_sync.sv */
`timescale 1ns/1ps
module cmp_sync
	import cmp_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic async_in,
	output logic sync_out
);
	logic [SYNC_STAGES-1:0] stage;
	// Only the last stage is visible outside
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage <= '0;
		end else begin
			stage <= {stage[SYNC_STAGES-2:0], async_in};
		end
	end
	assign sync_out = stage[SYNC_STAGES-1];
endmodule // cmp_sync

/* File: cmp_edge.sv */
`timescale 1ns/1ps
module cmp_edge
	import cmp_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic level,
	input wire logic [1:0] mode,
	output logic event_pulse
);
	logic prev;
	wire rise = level & ~prev;
	wire fall = ~level & prev;
	wire hit = (mode == MODE_TOGGLE) ? (rise | fall) :
		(mode == MODE_FALL) ? fall :
		(mode == MODE_RISE) ? rise : 1'b0;
	// Previous value is reset low, so a high level after reset reads as one rising edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev <= 1'b0;
		end else begin
			prev <= level;
		end
	end
	assign event_pulse = hit;
endmodule // cmp_edge

/* File: comparator_control_logic.sv */
// The APB register port was decided locally.
`timescale 1ns/1ps
// Behaviour
// - Raw result high when selected positive input exceeds selected negative input.
// - Negative input is channel pin when negmux enabled and converter off, else pin.
// - Bandgap select routes the reference to the positive input, else positive pin.
// - Raw result is synchronised before it reads as the output bit.
// - Event flag set by hardware on the selected event of the synchronised output.
// - Mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge.
// - Interrupt request only while flag, local enable and global enable are set.
// - Flag clears when the processor takes the comparator vector.
// - Writing one to the flag clears it; zero leaves it.
// - Power off bit removes comparator power; writable any time.
// - Bit 2 of control/status reads zero, writes ignored.
module comparator_control_logic
	import cmp_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmp_raw,
	input wire logic vector_ack,
	output logic cmp_power_off,
	output logic bandgap_select,
	output logic neg_sel_channel,
	output logic [1:0] channel_select_low,
	output logic cmp_irq_req,
	output logic irq
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] conv_b;
	logic cs_power_off;
	logic cs_bandgap;
	logic cmp_event_flag;
	logic cmp_irq_enable;
	logic [1:0] event_mode;
	logic [EXT_BITS-1:0] ctrl_ext;
	logic irq_status;
	logic irq_enable;
	logic cmp_output_bit;
	logic event_pulse;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire access = psel & penable;
	wire wr = access & pwrite & pstrb[0];
	wire rd = access & ~pwrite;
	wire [ADDR_W-1:0] idx = paddr[ADDR_LSB+ADDR_W-1:ADDR_LSB];
	wire aligned = (paddr[ADDR_LSB-1:0] == 2'b00) & (paddr[31:ADDR_LSB+ADDR_W] == '0);
	wire hit_b = aligned & (idx == IDX_CONV_B);
	wire hit_cs = aligned & (idx == IDX_CMP_CS);
	wire hit_st = aligned & (idx == IDX_IRQ_STATUS);
	wire hit_en = aligned & (idx == IDX_IRQ_ENABLE);
	wire hit_cl = aligned & (idx == IDX_IRQ_CLEAR);
	wire hit_ext = aligned & (idx == IDX_CTRL_EXT);
	wire mapped = hit_b | hit_cs | hit_st | hit_en | hit_cl | hit_ext;
	wire wr_b = wr & hit_b;
	wire wr_cs = wr & hit_cs;
	wire wr_en = wr & hit_en;
	wire wr_cl = wr & hit_cl;
	wire wr_ext = wr & hit_ext;

	wire negmux_enable = conv_b[CONV_B_NEGMUX];
	wire converter_enable = ctrl_ext[EXT_CONV_EN];
	wire global_irq_enable = ctrl_ext[EXT_GLOBAL_IE];
	wire [1:0] chan = ctrl_ext[EXT_CHAN_HI:EXT_CHAN_LO];

	// Bit 2 is built as a constant zero
	wire [7:0] cs_read = {cs_power_off, cs_bandgap, cmp_output_bit, cmp_event_flag,
		cmp_irq_enable, 1'b0, event_mode};
	wire [31:0] next_prdata =
		hit_b ? {24'h000000, conv_b} :
		hit_cs ? {24'h000000, cs_read} :
		hit_st ? {31'h00000000, irq_status} :
		hit_en ? {31'h00000000, irq_enable} :
		hit_ext ? {28'h0000000, ctrl_ext} :
		RDATA_UNMAPPED;

	// ----------------------------------------
	// Analog path: synchroniser and event detection
	// ----------------------------------------
	// cmp_raw is the analog core's result, already the comparison of the routed inputs
	cmp_sync u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in(cmp_raw),
		.sync_out(cmp_output_bit)
	);
	cmp_edge u_edge (
		.clk(clk),
		.sys_rst(sys_rst),
		.level(cmp_output_bit),
		.mode(event_mode),
		.event_pulse(event_pulse)
	);

	// Hardware set wins over any clear in the same cycle
	wire flag_clr = vector_ack | (wr_cs & pwdata[CS_FLAG]);
	wire next_flag = event_pulse | (cmp_event_flag & ~flag_clr);
	wire next_status = event_pulse | (irq_status & ~(wr_cl & pwdata[IRQ_EVENT]));
	wire next_req = next_flag & cmp_irq_enable & global_irq_enable;
	wire next_neg = negmux_enable & ~converter_enable;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_b <= CONV_B_RESET;
			cs_power_off <= 1'b0;
			cs_bandgap <= 1'b0;
			cmp_irq_enable <= 1'b0;
			event_mode <= MODE_TOGGLE;
			ctrl_ext <= '0;
			irq_enable <= 1'b0;
		end else begin
			if (wr_b) begin
				conv_b <= pwdata[7:0] & CONV_B_WMASK;
			end
			if (wr_cs) begin
				cs_power_off <= pwdata[CS_POWER_OFF];
				cs_bandgap <= pwdata[CS_BANDGAP];
				cmp_irq_enable <= pwdata[CS_IRQ_EN];
				event_mode <= pwdata[CS_MODE_HI:CS_MODE_LO];
			end
			if (wr_ext) begin
				ctrl_ext <= pwdata[EXT_BITS-1:0];
			end
			if (wr_en) begin
				irq_enable <= pwdata[IRQ_EVENT];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmp_event_flag <= 1'b0;
			irq_status <= 1'b0;
		end else begin
			cmp_event_flag <= next_flag;
			irq_status <= next_status;
		end
	end

	// Outputs to the analog core are registered copies
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmp_power_off <= 1'b0;
			bandgap_select <= 1'b0;
			neg_sel_channel <= 1'b0;
			channel_select_low <= 2'b00;
			cmp_irq_req <= 1'b0;
			irq <= 1'b0;
		end else begin
			cmp_power_off <= cs_power_off;
			bandgap_select <= cs_bandgap;
			neg_sel_channel <= next_neg;
			channel_select_low <= chan;
			cmp_irq_req <= next_req;
			irq <= next_status & irq_enable;
		end
	end

	// ----------------------------------------
	// APB answer: zero wait states
	// ----------------------------------------
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			if (psel & ~penable & ~pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic req_d;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			req_d <= 1'b0;
		end else begin
			req_d <= rd;
		end
	end

	AST_REQ_NEEDS_ALL: assert property (@(posedge clk) disable iff (sys_rst)
		cmp_irq_req |-> $past(cmp_irq_enable & global_irq_enable))
		else $error("Interrupt request without both enables");
	AST_FLAG_ON_EVENT: assert property (@(posedge clk) disable iff (sys_rst)
		event_pulse |=> cmp_event_flag)
		else $error("Event did not set the flag");
	AST_VECTOR_CLEARS: assert property (@(posedge clk) disable iff (sys_rst)
		(vector_ack & ~event_pulse) |=> ~cmp_event_flag)
		else $error("Vector did not clear the flag");
	AST_W1C_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
		(wr_cs & ~pwdata[CS_FLAG] & ~vector_ack & cmp_event_flag) |=> cmp_event_flag)
		else $error("Writing zero changed the flag");
	AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
		(pready & rd & hit_cs) |-> (prdata[2] == 1'b0))
		else $error("Reserved bit read as one");
	AST_FALL_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
		(event_mode == MODE_FALL && event_pulse) |-> (!cmp_output_bit && $past(cmp_output_bit)))
		else $error("Fall event without a falling edge");
	AST_TOGGLE_EVENT: assert property (@(posedge clk) disable iff (sys_rst)
		(event_mode == MODE_TOGGLE && (cmp_output_bit != $past(cmp_output_bit))) |-> event_pulse)
		else $error("Toggle missed in toggle mode");
	AST_READY_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
		pready |=> ~pready)
		else $error("Ready held longer than one cycle");
	AST_ERR_WITH_READY: assert property (@(posedge clk) disable iff (sys_rst)
		pslverr |-> pready)
		else $error("Slave error without ready");
	AST_BANDGAP_FOLLOWS: assert property (@(posedge clk) disable iff (sys_rst)
		wr_cs |-> ##2 (bandgap_select == $past(pwdata[CS_BANDGAP], 2)))
		else $error("Bandgap select not applied");
	AST_RESERVED_MODE: assert property (@(posedge clk) disable iff (sys_rst)
		(event_mode == MODE_RESVD) |-> ~event_pulse)
		else $error("Event in reserved mode");
	AST_RISE_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
		(event_mode == MODE_RISE && event_pulse) |-> (cmp_output_bit && !$past(cmp_output_bit)))
		else $error("Rise event without a rising edge");
	AST_SYNC_LAT: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(cmp_raw) ##1 cmp_raw |-> ##1 cmp_output_bit)
		else $error("Output bit latency above two cycles");
	AST_NEG_ROUTE: assert property (@(posedge clk) disable iff (sys_rst)
		converter_enable |=> ~neg_sel_channel)
		else $error("Channel routed while converter on");
	AST_POWER_FOLLOWS: assert property (@(posedge clk) disable iff (sys_rst)
		wr_cs |-> ##2 (cmp_power_off == $past(pwdata[CS_POWER_OFF], 2)))
		else $error("Power off bit not applied");
endmodule // comparator_control_logic

/* File: cmp_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Analog core and processor stand-in
// ----------------------------------------
module cmp_partner (
	input wire logic clk,
	input wire logic [7:0] pos_v,
	input wire logic [7:0] neg_v,
	input wire logic [7:0] gap_v,
	input wire logic [31:0] chan_v,
	input wire logic power_off,
	input wire logic gap_sel,
	input wire logic neg_chan,
	input wire logic [1:0] chan,
	input wire logic irq_req,
	input wire logic take,
	output logic raw,
	output logic ack
);
	logic [7:0] p;
	logic [7:0] n;
	assign p = gap_sel ? gap_v : pos_v;
	assign n = neg_chan ? chan_v[chan * 8 +: 8] : neg_v;
	// Unpowered core gives a steady low, never a stale compare
	assign raw = !power_off && (p > n);
	initial ack = 1'b0;
	always @(posedge clk) begin
		ack <= take && irq_req && !ack;
	end
endmodule // cmp_partner

/* File: test_comparator_control_logic.sv */
`timescale 1ns/1ps
module test_comparator_control_logic;
	import cmp_pkg::*;
	logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, take = 0;
	logic [31:0] paddr = 0, pwdata = 0, chan_v = 0, rd;
	logic [3:0] pstrb = 4'hf;
	logic [7:0] pos_v = 0, neg_v = 8'h80, gap_v = 8'h40;
	logic err, bg, nm, ce;
	logic [1:0] ch;
	int error_cnt = 0, tests_run = 0, seed = 32'h14c0;
	logic [31:0] prdata;
	logic pready, pslverr, raw, ack, cmp_power_off, bandgap_select;
	logic neg_sel_channel, cmp_irq_req, irq;
	logic [1:0] channel_select_low;
	always #5 clk = ~clk;
	comparator_control_logic dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmp_raw(raw), .vector_ack(ack),
		.cmp_power_off(cmp_power_off), .bandgap_select(bandgap_select),
		.neg_sel_channel(neg_sel_channel), .channel_select_low(channel_select_low),
		.cmp_irq_req(cmp_irq_req), .irq(irq));
	cmp_partner partner_u (.clk(clk), .pos_v(pos_v), .neg_v(neg_v), .gap_v(gap_v), .chan_v(chan_v),
		.power_off(cmp_power_off), .gap_sel(bandgap_select), .neg_chan(neg_sel_channel),
		.chan(channel_select_low), .irq_req(cmp_irq_req), .take(take), .raw(raw), .ack(ack));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Entered just after a rising edge; an idle cycle follows each transfer
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk iff (pready === 1'b1));
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	function automatic logic f_raw();
		logic [7:0] p;
		logic [7:0] n;
		p = bg ? gap_v : pos_v;
		n = (nm && !ce) ? chan_v[ch * 8 +: 8] : neg_v;
		return p > n;
	endfunction
	function automatic logic exp_ev(input int m, input logic r);
		return m == 0 || (m == 3 && r) || (m == 2 && !r);
	endfunction
	task end_of_test();
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#200000;
		error_cnt++;
		end_of_test();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		bg = 0;
		nm = 0;
		ce = 0;
		ch = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 0;
		@(posedge clk);
		apb(0, 32'h0c, 0);
		chk(rd, 0);
		apb(0, 32'h20, 0);
		chk(rd, 0);
		apb(1, 32'h30, 32'hff);
		chk(err, 1);
		apb(0, 32'h22, 0);
		chk(err, 1);
		chk(rd, 0);
		apb(1, 32'h20, 32'h47);
		bg = 1;
		repeat (8) @(posedge clk);
		apb(0, 32'h20, 0);
		chk(rd, {25'h0, 1'b1, f_raw(), 5'h03});
		chk(bandgap_select, 1);
		pstrb <= 0;
		apb(1, 32'h20, 32'h80);
		pstrb <= 4'hf;
		apb(0, 32'h20, 0);
		chk(rd[7], 0);
		apb(1, 32'h20, 0);
		bg = 0;
		for (int i = 0; i < 16; i++) begin
			nm = i[0];
			ce = i[1];
			ch = i[3:2];
			pos_v <= 8'($random(seed));
			neg_v <= 8'($random(seed));
			chan_v <= $random(seed);
			apb(1, 32'h0c, {25'h0, nm, 6'h0});
			apb(1, 32'h4c, {28'h0, ch, 1'b0, ce});
			@(negedge clk);
			chk(neg_sel_channel, nm & !ce);
			chk(channel_select_low, ch);
			@(posedge clk);
			apb(0, 32'h20, 0);
			chk(rd[5], f_raw());
		end
		nm = 0;
		pos_v <= 0;
		neg_v <= 8'h80;
		apb(1, 32'h0c, 0);
		repeat (4) @(posedge clk);
		for (int m = 0; m < 4; m++) begin
			apb(1, 32'h20, 32'h10 | m);
			apb(0, 32'h20, 0);
			chk(rd[4], 0);
			for (int e = 0; e < 2; e++) begin
				pos_v <= e ? 8'h00 : 8'hff;
				repeat (4) @(posedge clk);
				apb(1, 32'h20, m);
				apb(0, 32'h20, 0);
				chk(rd[4], exp_ev(m, !e));
				apb(1, 32'h20, 32'h10 | m);
				apb(0, 32'h20, 0);
				chk(rd[4], 0);
			end
		end
		apb(1, 32'h48, 1);
		pos_v <= 8'hff;
		repeat (4) @(posedge clk);
		for (int k = 0; k < 4; k++) begin
			apb(1, 32'h20, {28'h0, k[0], 3'h3});
			apb(1, 32'h4c, {30'h0, k[1], 1'b0});
			@(negedge clk);
			chk(cmp_irq_req, k == 3);
			@(posedge clk);
		end
		take <= 1;
		repeat (4) @(posedge clk);
		take <= 0;
		apb(0, 32'h20, 0);
		chk({rd[4], cmp_irq_req}, 0);
		apb(0, 32'h40, 0);
		chk(rd, 1);
		chk(irq, 0);
		apb(1, 32'h44, 1);
		@(negedge clk);
		chk(irq, 1);
		@(posedge clk);
		apb(1, 32'h44, 0);
		@(negedge clk);
		chk(irq, 0);
		@(posedge clk);
		apb(1, 32'h44, 1);
		apb(1, 32'h48, 1);
		apb(0, 32'h40, 0);
		chk(rd, 0);
		@(negedge clk);
		chk(irq, 0);
		@(posedge clk);
		apb(1, 32'h20, 0);
		apb(1, 32'h20, 32'h80);
		apb(0, 32'h20, 0);
		chk({rd[7], cmp_power_off}, 3);
		end_of_test();
	end
endmodule // test_comparator_control_logic
